//--- core/cfg_word_regs.svh
/*
  Offsets, field positions, reset values and timing counts of the configuration word decoder.
  Assumes it is included by bare name wherever these constants are needed.
*/
`ifndef CFG_WORD_REGS_SVH
`define CFG_WORD_REGS_SVH

// Register indices of the configuration words; the byte address is four times the index.
`define CFG_WORD_ONE_IDX 16'h2007
`define CFG_WORD_TWO_IDX 16'h2008
// Byte addresses of the registers without a printed location.
`define PWR_CTRL_ADDR 16'h0000
`define DECODE_STAT_ADDR 16'h0004

// Word one fields.
`define W1_CODE_PROT 13
`define W1_CCP2_MUX 12
`define W1_DEBUG_N 11
`define W1_BOR_V_HI 8
`define W1_BOR_V_LO 7
`define W1_BOR_EN 6
`define W1_MASTER_CLEAR_N_EN 5
`define W1_OSC_HI 4
`define W1_POWERUP_TIMER_EN_N 3
`define W1_WDT_EN 2
// Word two fields.
`define W2_BOR_SW_EN 6
`define W2_SWITCHOVER 1
`define W2_FAILSAFE 0
// Power control register field.
`define PWR_BOR_RUN_EN 2

// Unprogrammed cells read as one; unimplemented bits are forced to one.
`define CFG_ERASED 14'h3FFF
`define W1_UNIMP_MASK 14'h0600
`define W2_UNIMP_MASK 14'h3FBC
`define PWR_CTRL_RESET 32'h0000_0004

// Protected program memory tops.
`define PROT_TOP_LARGE 13'h1FFF
`define PROT_TOP_SMALL 13'h0FFF

// Brown-out trip voltages in millivolts.
`define BOR_MV_11 13'd2000
`define BOR_MV_10 13'd2700
`define BOR_MV_01 13'd4200
`define BOR_MV_00 13'd4500

// Timing.
`define PCLK_MHZ 250
`define POWERUP_TIMER_MS 72
`define POWERUP_TIMER_CYCLES (`POWERUP_TIMER_MS * 1000 * `PCLK_MHZ)
`define OST_OSC_CYCLES 1024

`endif

//--- core/cfg_word_pkg.sv
/*
  Types shared by the configuration word decoder.
  Assumes nothing of its surroundings.
*/
package cfg_word_pkg;

  typedef enum logic [2:0] {
    OSC_LP, OSC_XT, OSC_HS, OSC_EXTERNAL_CLOCK_IN,
    OSC_INTERNAL_RC_OSC_IO, OSC_INTERNAL_RC_OSC_CLOCK_OUT, OSC_EXTERNAL_RC_OSC_IO, OSC_EXTERNAL_RC_OSC_CLOCK_OUT
  } osc_mode_t;

  typedef enum logic [1:0] {
    BOR_OFF, BOR_SOFTWARE, BOR_SLEEP_OFF, BOR_ALWAYS
  } bor_mode_t;

  typedef enum logic [2:0] {
    ST_LOAD, ST_POWERUP_TIMER, ST_OST, ST_BOR, ST_RUN
  } seq_state_t;

  typedef struct packed {
    logic code_protect_active;
    logic [12:0] protect_top;
    logic ccp2_alt_pin;
    logic debugger_enable;
    logic [1:0] brownout_threshold_sel;
    logic [12:0] brownout_trip_mv;
    bor_mode_t brownout_mode;
    logic master_clear_pin_enable;
    logic powerup_timer_enable;
    logic watchdog_enable;
    logic [2:0] oscillator_select;
    osc_mode_t osc_mode;
    logic crystal_mode;
    logic clock_out_enable;
    logic osc_in_pin_io;
    logic osc_out_pin_io;
    logic clock_switchover_enable;
    logic failsafe_clock_monitor_enable;
  } cfg_decoded_t;

endpackage

//--- core/config_word_decode.sv
/*
  Configuration word store and decoder with an APB slave, plus the power-up
  and oscillator start-up hold sequence that the decoded settings drive.
  Assumes a single 250 MHz pclk; all pins arrive asynchronous to it.
*/
// Summary of operation
// - A programmed bit reads 0, an unprogrammed bit reads 1; decoding follows that.
// - The two words sit at locations 2007h and 2008h.
// - The words are reachable only in programming mode, never from running code.
// - Word one bit 13 low protects 0000h-1FFFh or 0000h-0FFFh by variant.
// - Word one bit 11 low enables the debugger and claims port B pins 6, 7.
// - Word one bits 10 and 9 are unimplemented and read 1.
// - Word one bits 8-7 pick 2.0, 2.7, 4.2 or 4.5 V brown-out threshold.
// - Brown-out enable pair 11 always on, 10 off in sleep, 00 disabled.
// - Pair 01 hands brown-out enabling to power control bit 2.
// - Word two bit 6 is the brown-out software enable, paired with word one bit 6.
// - Word one bit 5 high gives active-low master clear, else input, clear held high.
// - Word one bit 3 low enables the power-up timer.
// - Word one bit 2 high enables the watchdog.
// - Oscillator select is word one bit 4 and bits 1-0; 010 HS, 001 XT, 000 LP.
// - Codes 111, 110 are external RC; clock-out on second pin for 111 only.
// - Codes 101, 100 are internal RC; first pin I/O, second clock-out on 101.
// - Code 011 is external clock in with the second pin as port I/O.
// - Word two bits 13-7 and 5-2 are unimplemented and read 1.
// - Word two bit 1 enables two-speed clock switchover.
// - Word two bit 0 enables the fail-safe clock monitor.
// - An enabled power-up timer holds reset 72 ms, on power-up and after a brown-out.
// - The 1024 oscillator cycle start-up delay applies to crystal modes on power-up or wake.
`timescale 1ns/100ps
`include "cfg_word_regs.svh"

module config_word_decode
  import cfg_word_pkg::*;
#(
  parameter bit LARGE_MEMORY = 1'b1,
  parameter int POWERUP_TIMER_CYCLES = `POWERUP_TIMER_CYCLES,
  parameter int OST_CYCLES = `OST_OSC_CYCLES
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and device status.
  input wire logic programming_mode,
  input wire logic master_clear_pin,
  input wire logic osc_in_pin,
  input wire logic sleep_active,
  input wire logic wake_from_sleep,
  input wire logic brownout_detect,
  // Decoded settings and reset control.
  output cfg_decoded_t cfg_settings,
  output logic brownout_reset_enable,
  output logic master_clear_n,
  output logic master_clear_pin_input,
  output logic device_reset_hold
);

  localparam int SYNC_W = 6;
  localparam logic [15:0] W1_ADDR = 16'(`CFG_WORD_ONE_IDX * 4);
  localparam logic [15:0] W2_ADDR = 16'(`CFG_WORD_TWO_IDX * 4);

  function automatic cfg_decoded_t decode_cfg(input logic [13:0] w1, input logic [13:0] w2);
    cfg_decoded_t c;
    logic [13:0] a;
    logic [13:0] b;
    a = w1 | `W1_UNIMP_MASK;
    b = w2 | `W2_UNIMP_MASK;
    c = '0;
    c.code_protect_active = ~a[`W1_CODE_PROT];
    c.protect_top = LARGE_MEMORY ? `PROT_TOP_LARGE : `PROT_TOP_SMALL;
    c.ccp2_alt_pin = ~a[`W1_CCP2_MUX];
    c.debugger_enable = ~a[`W1_DEBUG_N];
    c.brownout_threshold_sel = a[`W1_BOR_V_HI:`W1_BOR_V_LO];
    case (c.brownout_threshold_sel)
      2'h3: c.brownout_trip_mv = `BOR_MV_11;
      2'h2: c.brownout_trip_mv = `BOR_MV_10;
      2'h1: c.brownout_trip_mv = `BOR_MV_01;
      default: c.brownout_trip_mv = `BOR_MV_00;
    endcase
    case ({a[`W1_BOR_EN], b[`W2_BOR_SW_EN]})
      2'h3: c.brownout_mode = BOR_ALWAYS;
      2'h2: c.brownout_mode = BOR_SLEEP_OFF;
      2'h1: c.brownout_mode = BOR_SOFTWARE;
      default: c.brownout_mode = BOR_OFF;
    endcase
    c.master_clear_pin_enable = a[`W1_MASTER_CLEAR_N_EN];
    c.powerup_timer_enable = ~a[`W1_POWERUP_TIMER_EN_N];
    c.watchdog_enable = a[`W1_WDT_EN];
    c.oscillator_select = {a[`W1_OSC_HI], a[1:0]};
    case (c.oscillator_select)
      3'h7: c.osc_mode = OSC_EXTERNAL_RC_OSC_CLOCK_OUT;
      3'h6: c.osc_mode = OSC_EXTERNAL_RC_OSC_IO;
      3'h5: c.osc_mode = OSC_INTERNAL_RC_OSC_CLOCK_OUT;
      3'h4: c.osc_mode = OSC_INTERNAL_RC_OSC_IO;
      3'h3: c.osc_mode = OSC_EXTERNAL_CLOCK_IN;
      3'h2: c.osc_mode = OSC_HS;
      3'h1: c.osc_mode = OSC_XT;
      default: c.osc_mode = OSC_LP;
    endcase
    c.crystal_mode = (c.oscillator_select <= 3'h2);
    c.clock_out_enable = (c.osc_mode == OSC_EXTERNAL_RC_OSC_CLOCK_OUT) || (c.osc_mode == OSC_INTERNAL_RC_OSC_CLOCK_OUT);
    c.osc_in_pin_io = (c.osc_mode == OSC_INTERNAL_RC_OSC_CLOCK_OUT) || (c.osc_mode == OSC_INTERNAL_RC_OSC_IO);
    c.osc_out_pin_io = (c.osc_mode == OSC_EXTERNAL_RC_OSC_IO) || (c.osc_mode == OSC_INTERNAL_RC_OSC_IO)
        || (c.osc_mode == OSC_EXTERNAL_CLOCK_IN);
    c.clock_switchover_enable = b[`W2_SWITCHOVER];
    c.failsafe_clock_monitor_enable = b[`W2_FAILSAFE];
    return c;
  endfunction

  // Two-stage synchroniser for every pin; only stage two is read by logic.
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic osc_prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // The clear pin stage resets high, its idle level, so no false clear follows reset.
      sync1_q <= 6'h02;
      sync2_q <= 6'h02;
      osc_prev_q <= 1'b0;
    end else begin
      sync1_q <= {brownout_detect, wake_from_sleep, sleep_active, osc_in_pin,
                  master_clear_pin, programming_mode};
      sync2_q <= sync1_q;
      osc_prev_q <= sync2_q[2];
    end
  end

  logic prog_s;
  logic master_clear_n_pin_s;
  logic osc_s;
  logic sleep_s;
  logic wake_s;
  logic bor_det_s;
  logic osc_rise;
  assign {bor_det_s, wake_s, sleep_s, osc_s, master_clear_n_pin_s, prog_s} = sync2_q;
  assign osc_rise = osc_s & ~osc_prev_q;

  // APB decode; every access gets one wait-free access phase.
  logic setup_phase;
  logic access_done;
  logic hit_w1;
  logic hit_w2;
  logic hit_pwr;
  logic hit_stat;
  logic cfg_hit;
  logic bad_access;
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign hit_w1 = (paddr == W1_ADDR);
  assign hit_w2 = (paddr == W2_ADDR);
  assign hit_pwr = (paddr == `PWR_CTRL_ADDR);
  assign hit_stat = (paddr == `DECODE_STAT_ADDR);
  assign cfg_hit = hit_w1 | hit_w2;
  // Config words answer only while the programmer holds the device in programming mode.
  assign bad_access = ~(hit_w1 | hit_w2 | hit_pwr | hit_stat) | (cfg_hit & ~prog_s)
      | (hit_stat & pwrite);

  // Non-volatile words; cells left unprogrammed read as one.
  // Reset leaves them alone, otherwise programmed settings could never take effect.
  logic [13:0] word_one_q = `CFG_ERASED;
  logic [13:0] word_two_q = `CFG_ERASED;
  always_ff @(posedge pclk) begin
    if (access_done && pwrite && prog_s) begin
      if (hit_w1) begin
        word_one_q <= pwdata[13:0] | `W1_UNIMP_MASK;
      end
      if (hit_w2) begin
        word_two_q <= pwdata[13:0] | `W2_UNIMP_MASK;
      end
    end
  end

  logic [31:0] pwr_ctrl_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_ctrl_q <= `PWR_CTRL_RESET;
    end else if (access_done && pwrite && hit_pwr) begin
      pwr_ctrl_q <= {29'h0, pwdata[`PWR_BOR_RUN_EN], 2'h0};
    end
  end

  // Settings are captured once after reset so later programming cannot disturb a running part.
  seq_state_t state_q;
  logic [31:0] count_q;
  cfg_decoded_t cfg_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= '0;
    end else if (state_q == ST_LOAD) begin
      cfg_q <= decode_cfg(word_one_q, word_two_q);
    end
  end
  assign cfg_settings = cfg_q;

  logic brownout_reset_enable_q;
  logic device_reset_hold_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup_phase;
      pslverr_q <= setup_phase & bad_access;
      if (setup_phase && !pwrite && !bad_access) begin
        prdata_q <= hit_w1 ? {18'h0, word_one_q} :
                    hit_w2 ? {18'h0, word_two_q} :
                    hit_pwr ? pwr_ctrl_q :
                    {24'h0, device_reset_hold_q, brownout_reset_enable_q, 1'b0,
                     2'(cfg_q.brownout_mode), 3'(state_q)};
      end else if (setup_phase) begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // Brown-out enable and master clear follow the latched settings.
  logic master_clear_n_q;
  logic master_clear_n_input_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brownout_reset_enable_q <= 1'b0;
      master_clear_n_q <= 1'b1;
      master_clear_n_input_q <= 1'b0;
    end else begin
      case (cfg_q.brownout_mode)
        BOR_ALWAYS: brownout_reset_enable_q <= 1'b1;
        BOR_SLEEP_OFF: brownout_reset_enable_q <= ~sleep_s;
        BOR_SOFTWARE: brownout_reset_enable_q <= pwr_ctrl_q[`PWR_BOR_RUN_EN];
        default: brownout_reset_enable_q <= 1'b0;
      endcase
      master_clear_n_q <= cfg_q.master_clear_pin_enable ? master_clear_n_pin_s : 1'b1;
      master_clear_n_input_q <= cfg_q.master_clear_pin_enable ? 1'b0 : master_clear_n_pin_s;
    end
  end
  assign brownout_reset_enable = brownout_reset_enable_q;
  assign master_clear_n = master_clear_n_q;
  assign master_clear_pin_input = master_clear_n_input_q;

  // Reset hold sequence: load, optional power-up timer, crystal start-up delay, run.
  // Counts are clipped at 32 bits; the timer counts pclk, not the slow RC the part uses.
  // The load step decodes the stored words directly, the same values cfg_q takes then.
  cfg_decoded_t load_cfg;
  logic powerup_timer_en;
  assign load_cfg = decode_cfg(word_one_q, word_two_q);
  assign powerup_timer_en = ~word_one_q[`W1_POWERUP_TIMER_EN_N];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_LOAD;
      count_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        ST_LOAD: begin
          count_q <= 32'h0000_0000;
          if (powerup_timer_en) begin
            state_q <= ST_POWERUP_TIMER;
          end else if (load_cfg.crystal_mode) begin
            state_q <= ST_OST;
          end else begin
            state_q <= ST_RUN;
          end
        end
        ST_POWERUP_TIMER: begin
          if (count_q == 32'(POWERUP_TIMER_CYCLES - 1)) begin
            count_q <= 32'h0000_0000;
            state_q <= cfg_q.crystal_mode ? ST_OST : ST_RUN;
          end else begin
            count_q <= count_q + 32'h0000_0001;
          end
        end
        ST_OST: begin
          if (osc_rise) begin
            if (count_q == 32'(OST_CYCLES - 1)) begin
              count_q <= 32'h0000_0000;
              state_q <= ST_RUN;
            end else begin
              count_q <= count_q + 32'h0000_0001;
            end
          end
        end
        ST_BOR: begin
          count_q <= 32'h0000_0000;
          if (!bor_det_s) begin
            state_q <= cfg_q.powerup_timer_enable ? ST_POWERUP_TIMER : ST_RUN;
          end
        end
        ST_RUN: begin
          count_q <= 32'h0000_0000;
          if (brownout_reset_enable_q && bor_det_s) begin
            state_q <= ST_BOR;
          end else if (wake_s && cfg_q.crystal_mode) begin
            state_q <= ST_OST;
          end
        end
        default: state_q <= ST_LOAD;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_reset_hold_q <= 1'b1;
    end else begin
      device_reset_hold_q <= (state_q != ST_RUN);
    end
  end
  assign device_reset_hold = device_reset_hold_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_load_once_static: assert property ((state_q != ST_LOAD) |=> $stable(cfg_q))
    else $error("decoded settings changed after load");
  a_word_one_unimp: assert property (word_one_q[10:9] == 2'h3)
    else $error("word one unimplemented bits not one");
  a_word_two_unimp: assert property (word_two_q[13:7] == 7'h7F && word_two_q[5:2] == 4'hF)
    else $error("word two unimplemented bits not one");
  a_words_locked_run: assert property (!prog_s |=> $stable(word_one_q) && $stable(word_two_q))
    else $error("config word changed outside programming");
  a_cfg_read_refused: assert property (setup_phase && cfg_hit && !prog_s |=> pslverr && pready)
    else $error("config access outside programming not refused");
  a_master_clear_n_gated_high: assert property (!cfg_q.master_clear_pin_enable |=> master_clear_n)
    else $error("master clear not held high");
  a_bor_sw_follow: assert property (cfg_q.brownout_mode == BOR_SOFTWARE
      |=> brownout_reset_enable == $past(pwr_ctrl_q[`PWR_BOR_RUN_EN]))
    else $error("software brown-out enable not followed");
  a_bor_sleep_off: assert property (cfg_q.brownout_mode == BOR_SLEEP_OFF && sleep_s
      |=> !brownout_reset_enable)
    else $error("brown-out not off in sleep");
  a_ost_crystal_only: assert property ((state_q == ST_OST) |-> cfg_q.crystal_mode
      || $past(state_q) == ST_LOAD)
    else $error("start-up delay outside crystal mode");
  a_powerup_timer_full_count: assert property ($rose(state_q == ST_POWERUP_TIMER) |-> count_q == 32'h0)
    else $error("power-up timer did not start from zero");
  a_hold_tracks_run: assert property ((state_q == ST_RUN) |=> !device_reset_hold)
    else $error("reset hold not released in run");
  a_hold_in_powerup_timer: assert property ((state_q == ST_POWERUP_TIMER) |=> device_reset_hold)
    else $error("reset hold dropped during power-up timer");
  a_ost_count_bound: assert property ((state_q == ST_OST) |-> count_q < 32'(OST_CYCLES))
    else $error("start-up count beyond its end");
  a_bor_always_on: assert property (cfg_q.brownout_mode == BOR_ALWAYS |=> brownout_reset_enable)
    else $error("brown-out not always on");
  a_bor_off_zero: assert property (cfg_q.brownout_mode == BOR_OFF |=> !brownout_reset_enable)
    else $error("brown-out enabled while disabled");
  a_pin_input_gated: assert property (cfg_q.master_clear_pin_enable |=> !master_clear_pin_input)
    else $error("pin input shown while pin is master clear");
  a_stat_write_refused: assert property (setup_phase && hit_stat && pwrite |=> pslverr)
    else $error("status write not refused");

  c_powerup_timer_path: cover property (state_q == ST_POWERUP_TIMER ##1 state_q == ST_OST);
  c_wake_ost: cover property (state_q == ST_RUN ##1 state_q == ST_OST);
  c_brownout: cover property (state_q == ST_BOR);
  c_prog_write: cover property (access_done && pwrite && hit_w1 && prog_s);
  c_sw_bor_off: cover property (cfg_q.brownout_mode == BOR_SOFTWARE && !brownout_reset_enable);

endmodule

//--- dv/cfg_programmer.sv
/*
  Programmer model: the APB master that writes configuration memory, and the programming pin.
  Assumes an APB slave on pclk that answers each access phase with pready.
*/
`timescale 1ns/100ps

module cfg_programmer (
  // Clock.
  input wire logic pclk,
  // APB master side.
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [15:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Programming entry pin.
  output logic programming_mode
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    programming_mode = 1'b0;
  end

  // Config words are only touched while this pin is held high.
  task automatic set_prog(input logic v);
    @(posedge pclk);
    programming_mode <= v;
  endtask

  // One APB transfer; released address and data lines are inverted so stale values never look valid.
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

//--- dv/config_word_decode_bench.sv
/*
  Self-checking bench for the configuration word decoder.
  Assumes the programmer model drives the APB side; reset leaves the stored words alone.
*/
`timescale 1ns/100ps

module config_word_decode_bench;
  import cfg_word_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, programming_mode, err;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic master_clear_pin, osc_in_pin, sleep_active, wake_from_sleep, brownout_detect;
  logic brownout_reset_enable, master_clear_n, master_clear_pin_input, device_reset_hold;
  cfg_decoded_t cfg_settings;
  logic [13:0] w1, w2;
  int miscompares, n_compared, n;

  config_word_decode #(.LARGE_MEMORY(1'b1), .POWERUP_TIMER_CYCLES(20), .OST_CYCLES(8)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .programming_mode(programming_mode), .master_clear_pin(master_clear_pin),
    .osc_in_pin(osc_in_pin), .sleep_active(sleep_active), .wake_from_sleep(wake_from_sleep),
    .brownout_detect(brownout_detect), .cfg_settings(cfg_settings),
    .brownout_reset_enable(brownout_reset_enable), .master_clear_n(master_clear_n),
    .master_clear_pin_input(master_clear_pin_input), .device_reset_hold(device_reset_hold));

  cfg_programmer prog (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .programming_mode(programming_mode));

  function automatic cfg_decoded_t exp_cfg(input logic [13:0] a, input logic [13:0] b);
    cfg_decoded_t c;
    logic [2:0] o;
    o = {a[4], a[1:0]};
    c.code_protect_active = ~a[13];
    c.protect_top = 13'h1FFF;
    c.ccp2_alt_pin = ~a[12];
    c.debugger_enable = ~a[11];
    c.brownout_threshold_sel = a[8:7];
    c.brownout_trip_mv = a[8] ? (a[7] ? 13'd2000 : 13'd2700) : (a[7] ? 13'd4200 : 13'd4500);
    c.brownout_mode = bor_mode_t'({a[6], b[6]});
    c.master_clear_pin_enable = a[5];
    c.powerup_timer_enable = ~a[3];
    c.watchdog_enable = a[2];
    c.oscillator_select = o;
    c.osc_mode = osc_mode_t'(o);
    c.crystal_mode = (o < 3'h3);
    c.clock_out_enable = (o == 3'h7) || (o == 3'h5);
    c.osc_in_pin_io = (o == 3'h4) || (o == 3'h5);
    c.osc_out_pin_io = (o == 3'h6) || (o == 3'h4) || (o == 3'h3);
    c.clock_switchover_enable = b[1];
    c.failsafe_clock_monitor_enable = b[0];
    return c;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Runs one transfer and compares the error response, and the read data on reads only.
  task automatic op(input logic wr, input logic [15:0] a, input logic [31:0] d,
                    input logic [31:0] erd, input logic eerr);
    prog.xfer(wr, a, d, rd, err);
    check(err, eerr);
    if (!wr) check(rd, erd);
  endtask

  task automatic wait_run();
    n = 0;
    while (device_reset_hold !== 1'b0 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    check(device_reset_hold, 1'b0);
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // The oscillator pin toggles steadily so a start-up count would have edges to see.
  always @(posedge pclk) osc_in_pin <= ~osc_in_pin;

  initial begin
    #20000;
    miscompares++;
    wrap_up();
  end

  initial begin
    presetn = 1'b0;
    master_clear_pin = 1'b1;
    osc_in_pin = 1'b0;
    sleep_active = 1'b0;
    wake_from_sleep = 1'b0;
    brownout_detect = 1'b0;
    miscompares = 0;
    n_compared = 0;
    w1 = 14'($urandom(17));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    wait_run();
    check(n < 10, 1'b1);
    check(cfg_settings, exp_cfg(14'h3FFF, 14'h3FFF));
    check(brownout_reset_enable, 1'b1);
    op(1'b0, 16'h801C, 32'h0, 32'h0, 1'b1);
    op(1'b0, 16'h0010, 32'h0, 32'h0, 1'b1);
    op(1'b1, 16'h0004, 32'h1, 32'h0, 1'b1);
    op(1'b0, 16'h0004, 32'h0, 32'h5C, 1'b0);
    op(1'b0, 16'h0000, 32'h0, 32'h4, 1'b0);
    prog.set_prog(1'b1);
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      w1 = (i == 0) ? 14'h0000 : (i == 1) ? 14'h3FFF : 14'($urandom());
      w2 = (i == 0) ? 14'h0000 : (i == 1) ? 14'h3FFF : 14'($urandom());
      op(1'b1, 16'h801C, {18'h0, w1}, 32'h0, 1'b0);
      op(1'b1, 16'h8020, {18'h0, w2}, 32'h0, 1'b0);
      op(1'b0, 16'h801C, 32'h0, {18'h0, w1 | 14'h0600}, 1'b0);
      op(1'b0, 16'h8020, 32'h0, {18'h0, w2 | 14'h3FBC}, 1'b0);
      check(cfg_settings, exp_cfg(14'h3FFF, 14'h3FFF));
    end
    op(1'b1, 16'h0000, 32'h0, 32'h0, 1'b0);
    op(1'b0, 16'h0000, 32'h0, 32'h0, 1'b0);
    check(brownout_reset_enable, 1'b1);
    sleep_active <= 1'b1;
    repeat (6) @(posedge pclk);
    check(brownout_reset_enable, 1'b1);
    sleep_active <= 1'b0;
    wake_from_sleep <= 1'b1;
    repeat (3) @(posedge pclk);
    wake_from_sleep <= 1'b0;
    repeat (8) @(posedge pclk);
    check(device_reset_hold, 1'b0);
    brownout_detect <= 1'b1;
    repeat (6) @(posedge pclk);
    check(device_reset_hold, 1'b1);
    brownout_detect <= 1'b0;
    wait_run();
    check(n < 10, 1'b1);
    master_clear_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    check(master_clear_n, 1'b0);
    check(master_clear_pin_input, 1'b0);
    master_clear_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    check(master_clear_n, 1'b1);
    prog.set_prog(1'b0);
    repeat (4) @(posedge pclk);
    op(1'b1, 16'h801C, 32'h0, 32'h0, 1'b1);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wait_run();
    check(cfg_settings, exp_cfg(w1, w2));
    prog.set_prog(1'b1);
    repeat (4) @(posedge pclk);
    op(1'b1, 16'h801C, 32'h0000_3F84, 32'h0, 1'b0);
    op(1'b1, 16'h8020, 32'h0000_3FFF, 32'h0, 1'b0);
    prog.set_prog(1'b0);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wait_run();
    check(n > 30 && n < 50, 1'b1);
    check(cfg_settings, exp_cfg(14'h3F84, 14'h3FFF));
    check(brownout_reset_enable, 1'b1);
    op(1'b1, 16'h0000, 32'h0, 32'h0, 1'b0);
    repeat (2) @(posedge pclk);
    check(brownout_reset_enable, 1'b0);
    master_clear_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    check(master_clear_n, 1'b1);
    check(master_clear_pin_input, 1'b0);
    master_clear_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    check(master_clear_pin_input, 1'b1);
    wake_from_sleep <= 1'b1;
    repeat (3) @(posedge pclk);
    wake_from_sleep <= 1'b0;
    repeat (2) @(posedge pclk);
    check(device_reset_hold, 1'b1);
    wait_run();
    wrap_up();
  end
endmodule
